// ---- hdl/sdp_pkg.sv ----
package sdp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and refresh timing
  localparam int MCLK_PERIOD_NS     = 40;                      // own clock period
  localparam int REFRESH_PERIOD_MS  = 64;                      // every row within this
  localparam int REFRESH_PERIOD_CYC = REFRESH_PERIOD_MS * 1_000_000 / MCLK_PERIOD_NS;
  localparam int ROW_COUNT          = 4096;                    // rows per refresh period
  // distributed interval, a longest time, so it rounds down
  localparam int ROW_INTERVAL_CYC   = REFRESH_PERIOD_CYC / ROW_COUNT;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int ROW_W   = 12;   // refresh row counter
  localparam int CNT_W   = 4;    // per-bank link-edge timers
  localparam int BEAT_W  = 4;    // burst beat counter
  localparam int CAS_LAT = 2;    // read pipeline depth in link edges
  localparam int SR_W    = 16;   // self refresh interval timer
  localparam int PD_W    = 32;   // power-down stay timer

  ////////////////////////////////////////////////////////////////////////////
  // timings counted in link clock edges; the row interval in own clock cycles
  localparam logic [CNT_W-1:0] ROW_PRECHARGE_CYC     = 4'h3;  // row_precharge_time
  localparam logic [CNT_W-1:0] WRITE_RECOVERY_CYC    = 4'h2;  // write_recovery_time
  localparam logic [CNT_W-1:0] REFRESH_CYCLE_CYC     = 4'h7;  // refresh_cycle_time
  localparam logic [CNT_W-1:0] SELF_REFRESH_EXIT_CYC = 4'h2;  // self_refresh_exit_time
  localparam logic [SR_W-1:0]  ROW_INTERVAL_LAST     = SR_W'(ROW_INTERVAL_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // command codes on ras_n, cas_n, we_n
  localparam logic [2:0] CMD_MRS   = 3'h0;
  localparam logic [2:0] CMD_REF   = 3'h1;
  localparam logic [2:0] CMD_PRE   = 3'h2;
  localparam logic [2:0] CMD_ACT   = 3'h3;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ  = 3'h5;
  localparam logic [2:0] CMD_BST   = 3'h6;
  localparam logic [2:0] CMD_NOP   = 3'h7;
  localparam logic [3:0] ALL_BANKS = 4'hF;

  // operating modes, one-hot
  typedef enum logic [3:0] {
    MODE_NORMAL = 4'h1,
    MODE_PDOWN  = 4'h2,
    MODE_SELF   = 4'h4,
    MODE_EXIT   = 4'h8
  } sdp_mode_type;

  // controller pins as seen on one link edge
  typedef struct packed {
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
    logic clockEnable;
    logic bankSelectBit1;
    logic bankSelectBit0;
    logic prechargeSelectAddrBit;
    logic dataMask;
  } sdp_pins_type;

  // whole state of the bank and power logic
  typedef struct packed {
    sdp_mode_type                  mode;
    logic                          ckePrev;
    logic [3:0]                    bankOpen;
    logic [3:0][CNT_W-1:0]         prech;
    logic [3:0][CNT_W-1:0]         wrRec;
    logic                          burstOn;
    logic                          burstWr;
    logic                          burstAp;
    logic                          burstCont;
    logic [1:0]                    burstBank;
    logic [BEAT_W-1:0]             beatLeft;
    logic [CAS_LAT-1:0]            readPipe;
    logic [CNT_W-1:0]              rfcCnt;
    logic [CNT_W-1:0]              xsrCnt;
    logic [ROW_W-1:0]              rowCnt;
    logic [SR_W-1:0]               srTimer;
    logic [PD_W-1:0]               pdTimer;
    logic                          writeAccept;
    logic                          protoErr;
  } sdp_state_type;

endpackage : sdp_pkg

// ---- hdl/sdp_link_sampler.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdp_link_sampler
  import sdp_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic         linkClk,
  input  wire sdp_pins_type pinsIn,
  output logic              linkEdge,
  output sdp_pins_type      pinsAtEdge
);

  // sampler state: two-stage synchronisers plus edge history
  typedef struct packed {
    logic         clkMeta;
    logic         clkSync;
    logic         clkOld;
    sdp_pins_type pinsMeta;
    sdp_pins_type pinsSync;
    logic         edgeSeen;
    sdp_pins_type pinsHeld;
  } sdp_sampler_type;

  sdp_sampler_type s;       // registered state
  sdp_sampler_type next_s;  // next state

  ////////////////////////////////////////////////////////////////////////////
  // meta stages feed only the sync stages; the 320 ns link period leaves
  // the pins settled long before the synced rising edge shows up
  always_comb begin
    next_s          = s;
    next_s.clkMeta  = linkClk;
    next_s.clkSync  = s.clkMeta;
    next_s.clkOld   = s.clkSync;
    next_s.pinsMeta = pinsIn;
    next_s.pinsSync = s.pinsMeta;
    next_s.edgeSeen = s.clkSync && !s.clkOld;
    if (s.clkSync && !s.clkOld) begin
      next_s.pinsHeld = s.pinsSync;  // capture pins on the rising edge
    end
  end

  // one register process for the whole state
  always_ff @(posedge mclk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign linkEdge   = s.edgeSeen;
  assign pinsAtEdge = s.pinsHeld;

endmodule : sdp_link_sampler
`default_nettype wire

// ---- hdl/sdp_bank_power_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdp_bank_power_ctrl
  import sdp_pkg::*;
#(
  parameter logic [BEAT_W-1:0] BURST_LEN    = 4'h4,               // fixed burst length
  parameter logic [PD_W-1:0]   PD_LIMIT_CYC = PD_W'(REFRESH_PERIOD_CYC)
)(
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic         linkClk,           // controller clock, 320 ns
  input  wire sdp_pins_type pins,              // command, bank, address, mask
  input  wire logic         continuousPage,    // burst length set to full page
  input  wire logic         singleWrite,       // write burst mode single location
  output logic [3:0]        bankOpen,          // row open per bank
  output logic [3:0]        bankPrecharging,   // precharge or recovery pending
  output logic              refreshBusy,       // refresh cycle time running
  output logic [ROW_W-1:0]  refreshRow,        // internal refresh row counter
  output logic              selfRefresh,       // in self refresh or its exit
  output logic              powerDown,         // precharge or active power-down
  output logic              activePowerDown,   // power-down with a row open
  output logic              powerDownOverstay, // power-down beyond refresh period
  output logic              clockSuspended,    // internal edges suspended
  output logic              writeAccept,       // write data taken on last edge
  output logic              readDrive,         // read data driven on output
  output logic              protocolError      // illegal command seen
);

  ////////////////////////////////////////////////////////////////////////////
  // link sampling

  logic         linkEdge;  // one pulse per link rising edge
  sdp_pins_type pin;       // pins registered at that edge

  sdp_link_sampler u_sampler (
    .mclk       (mclk),
    .reset      (reset),
    .linkClk    (linkClk),
    .pinsIn     (pins),
    .linkEdge   (linkEdge),
    .pinsAtEdge (pin)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode of the registered pins

  logic [2:0] cmd;       // ras, cas, we
  logic [1:0] bankSel;   // addressed bank
  logic [3:0] bankMask;  // addressed bank one-hot
  logic       isNop;     // no-op or command inhibit
  logic       execEdge;  // link edge that is not suspended, normal mode

  sdp_state_type s;       // registered state
  sdp_state_type next_s;  // next state

  assign cmd      = {pin.rasN, pin.casN, pin.weN};
  assign bankSel  = {pin.bankSelectBit1, pin.bankSelectBit0};
  assign bankMask = 4'h1 << bankSel;
  assign isNop    = pin.csN || (cmd == CMD_NOP);
  assign execEdge = linkEdge && (s.mode == MODE_NORMAL) && s.ckePrev;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [3:0]        startMask;  // banks whose precharge begins now
    logic [3:0]        busyMask;   // banks not yet ready
    logic              apDone;     // running burst hands over its auto precharge
    logic              rdBeat;     // read beat enters the latency pipe
    logic [BEAT_W-1:0] len;        // length of a new burst
    startMask = '0;
    busyMask  = '0;
    apDone    = 1'b0;
    rdBeat    = 1'b0;
    len       = BURST_LEN;
    next_s             = s;
    next_s.writeAccept = 1'b0;
    next_s.protoErr    = 1'b0;
    for (int b = 0; b < 4; b++) begin
      busyMask[b] = (s.prech[b] != '0) || (s.wrRec[b] != '0);
    end
    // power-down stay timer, saturating on our own clock
    if (s.mode == MODE_PDOWN) begin
      if (s.pdTimer != PD_LIMIT_CYC) begin
        next_s.pdTimer = s.pdTimer + 32'h0000_0001;
      end
    end else begin
      next_s.pdTimer = '0;
    end
    if (s.mode == MODE_SELF) begin
      if (s.srTimer == ROW_INTERVAL_LAST) begin
        next_s.srTimer = '0;
        next_s.rowCnt  = s.rowCnt + 12'h001;
      end else begin
        next_s.srTimer = s.srTimer + 16'h0001;
      end
    end else begin
      next_s.srTimer = '0;
    end
    if (linkEdge) begin
      next_s.ckePrev = pin.clockEnable;
      // timers run in real link time, suspended or not
      for (int b = 0; b < 4; b++) begin
        if (s.prech[b] != '0) begin
          next_s.prech[b] = s.prech[b] - 4'h1;
        end
        if (s.wrRec[b] == 4'h1) begin
          startMask[b] = 1'b1;  // recovery met, precharge begins
        end
        if (s.wrRec[b] != '0) begin
          next_s.wrRec[b] = s.wrRec[b] - 4'h1;
        end
      end
      if (s.rfcCnt != '0) begin
        next_s.rfcCnt = s.rfcCnt - 4'h1;
      end
      case (s.mode)
        MODE_NORMAL: begin
          // suspended edge: commands, data and burst beat count frozen
          if (s.ckePrev) begin
            // burst progress on this internal edge
            if (s.burstOn) begin
              if (s.burstCont || (s.beatLeft != '0)) begin
                rdBeat             = !s.burstWr;
                next_s.writeAccept = s.burstWr && !pin.dataMask;
                if (!s.burstCont) begin
                  next_s.beatLeft = s.beatLeft - 4'h1;
                end
              end else begin
                next_s.burstOn = 1'b0;
                apDone         = s.burstAp;
              end
            end
            // refresh cycle time: executable command refused
            if ((s.rfcCnt != '0) && !isNop) begin
              next_s.protoErr = 1'b1;
            end else if (!pin.csN) begin
              case (cmd)
                CMD_ACT: begin
                  // only an idle, settled bank may open
                  if (s.bankOpen[bankSel] || busyMask[bankSel]) begin
                    next_s.protoErr = 1'b1;
                  end else begin
                    next_s.bankOpen[bankSel] = 1'b1;
                  end
                end
                CMD_READ, CMD_WRITE: begin
                  if (!s.bankOpen[bankSel] ||
                      (s.burstOn && s.burstAp && (s.burstBank == bankSel))) begin
                    next_s.protoErr = 1'b1;
                  end else begin
                    // interrupted read: precharge from this edge
                    // write over read: mask keeps the bus clean
                    // read over write: this edge's data dropped
                    // write over write: recovery from this edge
                    if (s.burstOn && s.burstAp) begin
                      apDone = 1'b1;
                    end
                    if ((cmd == CMD_WRITE) && singleWrite) begin
                      len = 4'h1;
                    end
                    next_s.burstOn   = 1'b1;
                    next_s.burstWr   = (cmd == CMD_WRITE);
                    next_s.burstBank = bankSel;
                    next_s.burstCont = continuousPage;
                    next_s.burstAp   = pin.prechargeSelectAddrBit && !continuousPage;
                    next_s.beatLeft  = len - 4'h1;
                    rdBeat             = (cmd == CMD_READ);
                    next_s.writeAccept = (cmd == CMD_WRITE) && !pin.dataMask;
                  end
                end
                CMD_PRE: begin
                  // select bit picks one bank or all
                  if (pin.prechargeSelectAddrBit) begin
                    startMask = startMask | ALL_BANKS;
                  end else begin
                    startMask = startMask | bankMask;
                  end
                  // truncates a burst running in a closed bank
                  if (pin.prechargeSelectAddrBit || (s.burstBank == bankSel)) begin
                    next_s.burstOn     = 1'b0;
                    next_s.writeAccept = 1'b0;
                    rdBeat             = 1'b0;
                  end
                end
                CMD_BST: begin
                  next_s.burstOn     = 1'b0;
                  next_s.writeAccept = 1'b0;  // data at terminate ignored
                  rdBeat             = 1'b0;
                end
                CMD_REF: begin
                  // all banks idle; row comes from the counter
                  if ((s.bankOpen != '0) || (busyMask != '0) || s.burstOn) begin
                    next_s.protoErr = 1'b1;
                  end else begin
                    next_s.rowCnt = s.rowCnt + 12'h001;
                    if (pin.clockEnable) begin
                      next_s.rfcCnt = REFRESH_CYCLE_CYC;
                    end else begin
                      next_s.mode = MODE_SELF;
                    end
                  end
                end
                default: begin
                  // mode register and no-op: nothing here
                end
              endcase
            end
            // power-down only with no access in progress
            if (isNop && !pin.clockEnable && !next_s.burstOn && (s.rfcCnt == '0)) begin
              next_s.mode = MODE_PDOWN;
            end
          end
        end
        MODE_PDOWN: begin
          // no-op with clock enable high ends power-down
          if (pin.clockEnable && isNop) begin
            next_s.mode = MODE_NORMAL;
          end
        end
        MODE_SELF: begin
          // everything but clock enable ignored here
          if (pin.clockEnable) begin
            next_s.mode   = MODE_EXIT;
            next_s.xsrCnt = SELF_REFRESH_EXIT_CYC;
          end
        end
        MODE_EXIT: begin
          if (!isNop) begin
            next_s.protoErr = 1'b1;
          end
          if (s.xsrCnt <= 4'h1) begin
            next_s.mode   = MODE_NORMAL;
            next_s.xsrCnt = '0;
          end else begin
            next_s.xsrCnt = s.xsrCnt - 4'h1;
          end
        end
        default: begin
          next_s.mode = MODE_NORMAL;
        end
      endcase
      // pipe frozen on suspended edges, drive held
      if (!((s.mode == MODE_NORMAL) && !s.ckePrev)) begin
        next_s.readPipe = {s.readPipe[CAS_LAT-2:0], rdBeat};
      end
    end
    // hand over auto precharge of the old burst
    if (apDone) begin
      if (s.burstWr) begin
        next_s.wrRec[s.burstBank] = WRITE_RECOVERY_CYC;
      end else begin
        startMask[s.burstBank] = 1'b1;
      end
    end
    // close rows and start precharge timers
    for (int b = 0; b < 4; b++) begin
      if (startMask[b]) begin
        next_s.bankOpen[b] = 1'b0;
        next_s.prech[b]    = ROW_PRECHARGE_CYC;
      end
    end
  end

  // one register process, reset to all banks idle, normal mode
  always_ff @(posedge mclk) begin
    if (reset) begin
      s         <= '0;
      s.mode    <= MODE_NORMAL;
      s.ckePrev <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      bankPrecharging[b] = (s.prech[b] != '0) || (s.wrRec[b] != '0);
    end
  end

  assign bankOpen          = s.bankOpen;
  assign refreshBusy       = (s.rfcCnt != '0);
  assign refreshRow        = s.rowCnt;
  assign selfRefresh       = (s.mode == MODE_SELF) || (s.mode == MODE_EXIT);
  assign powerDown         = (s.mode == MODE_PDOWN);
  assign activePowerDown   = (s.mode == MODE_PDOWN) && (s.bankOpen != '0);
  assign powerDownOverstay = (s.mode == MODE_PDOWN) && (s.pdTimer == PD_LIMIT_CYC);
  assign clockSuspended    = (s.mode == MODE_NORMAL) && !s.ckePrev;
  assign writeAccept       = s.writeAccept;
  assign readDrive         = s.readPipe[CAS_LAT-1];
  assign protocolError     = s.protoErr;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  logic cmdOk;  // executable edge outside refresh cycle time
  assign cmdOk = execEdge && (s.rfcCnt == '0) && !pin.csN;

  sequence selfExitSeq;
    linkEdge && (s.mode == MODE_SELF) && pin.clockEnable;
  endsequence

  all_bank_close_a : assert property (
    cmdOk && (cmd == CMD_PRE) && pin.prechargeSelectAddrBit
    |=> (s.bankOpen == '0) && (s.prech[0] == ROW_PRECHARGE_CYC)
        && (s.prech[3] == ROW_PRECHARGE_CYC))
    else $error("all-bank precharge left a bank open");
  one_bank_close_a : assert property (
    cmdOk && (cmd == CMD_PRE) && !pin.prechargeSelectAddrBit
    |=> ((s.bankOpen & $past(bankMask)) == '0))
    else $error("single-bank precharge did not close its bank");
  act_busy_err_a : assert property (
    cmdOk && (cmd == CMD_ACT) && (s.prech[bankSel] != '0)
    |=> s.protoErr && !$past(s.bankOpen[bankSel])
        ##0 !s.bankOpen[$past(bankSel)])
    else $error("activate during precharge accepted");
  refresh_open_err_a : assert property (
    cmdOk && (cmd == CMD_REF) && (s.bankOpen != '0)
    |=> s.protoErr && (s.rowCnt == $past(s.rowCnt)))
    else $error("refresh with open bank accepted");
  selfref_entry_a : assert property (
    cmdOk && (cmd == CMD_REF) && !pin.clockEnable && (s.bankOpen == '0)
    && (bankPrecharging == '0) && !s.burstOn |=> (s.mode == MODE_SELF) && selfRefresh)
    else $error("self refresh not entered");
  self_exit_a : assert property (
    selfExitSeq |=> (s.mode == MODE_EXIT) && (s.xsrCnt == SELF_REFRESH_EXIT_CYC))
    else $error("self refresh exit not started");
  pdown_entry_a : assert property (
    execEdge && isNop && !pin.clockEnable && !s.burstOn && (s.rfcCnt == '0) |=> powerDown)
    else $error("power-down not entered");
  pdown_exit_a : assert property (
    linkEdge && powerDown && pin.clockEnable && isNop |=> !powerDown ##1 !powerDown)
    else $error("power-down not left");
  suspend_hold_a : assert property (
    linkEdge && clockSuspended && s.burstOn
    |=> $stable(s.beatLeft) && $stable(s.readPipe) && !s.writeAccept)
    else $error("burst moved on a suspended edge");

endmodule : sdp_bank_power_ctrl
`default_nettype wire

// ---- verif/sdp_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdp_ctrl_model
  import sdp_pkg::*;
(
  input  wire logic    mclk,
  output logic         linkClk,
  output sdp_pins_type pins
);
  // free controller clock, phase unrelated to mclk
  initial begin
    linkClk = 1'b0;
    pins = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    #7;
    forever #160 linkClk = ~linkClk;
  end
  // one command per link edge
  // held across the rise, then back to no-op so nothing repeats
  task automatic cmd(input logic [2:0] c, input logic [1:0] ba, input logic ap,
                     input logic cke);
    @(negedge linkClk);
    @(posedge mclk);
    #2 pins <= '{1'b0, c[2], c[1], c[0], cke, ba[1], ba[0], ap, 1'b0};
    @(posedge linkClk);
    @(posedge mclk);
    #2 pins <= '{1'b0, 1'b1, 1'b1, 1'b1, cke, 1'b0, 1'b0, 1'b0, 1'b0};
  endtask : cmd
endmodule : sdp_ctrl_model
`default_nettype wire

// ---- verif/sdp_bank_power_ctrl_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdp_bank_power_ctrl_tb_top;
  import sdp_pkg::*;
  logic mclk = 1'b0, reset = 1'b1, linkClk, continuousPage = 1'b0, singleWrite = 1'b0;
  sdp_pins_type pins;
  logic [3:0] bankOpen, bankPrecharging;
  logic [ROW_W-1:0] refreshRow;
  logic refreshBusy, selfRefresh, powerDown, activePowerDown, powerDownOverstay;
  logic clockSuspended, writeAccept, readDrive, protocolError;
  int fail_count = 0, n_compared = 0, errCnt = 0, wrCnt = 0;
  always #20 mclk = ~mclk;
  // refused commands only pulse, so count them
  always @(posedge mclk) if (protocolError === 1'b1) errCnt++;
  // accepted write beats pulse as well
  always @(posedge mclk) if (writeAccept === 1'b1) wrCnt++;
  sdp_ctrl_model m (.mclk, .linkClk, .pins);
  sdp_bank_power_ctrl #(.PD_LIMIT_CYC(32'h0000_0032)) dut (.mclk, .reset, .linkClk, .pins,
    .continuousPage, .singleWrite, .bankOpen, .bankPrecharging, .refreshBusy, .refreshRow,
    .selfRefresh, .powerDown, .activePowerDown, .powerDownOverstay, .clockSuspended,
    .writeAccept, .readDrive, .protocolError);
  task automatic c(input logic [2:0] k, input logic [1:0] ba, input logic ap);
    m.cmd(k, ba, ap, 1'b1);
  endtask : c
  task automatic n(input int k, input logic cke);
    repeat (k) m.cmd(CMD_NOP, 2'h0, 1'b0, cke);
  endtask : n
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done();
    if (fail_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic t_pre();
    int e;
    c(CMD_ACT, 2'h0, 1'b0); c(CMD_ACT, 2'h1, 1'b0); c(CMD_PRE, 2'h0, 1'b0); n(1, 1'b1);
    chk(bankOpen, 4'h2);
    chk(bankPrecharging, 4'h1);
    e = errCnt;
    // activate while bank 0 still precharges
    c(CMD_ACT, 2'h0, 1'b0); n(2, 1'b1); c(CMD_PRE, 2'h3, 1'b1); n(1, 1'b1);
    chk(bankOpen, 4'h0);
    n(3, 1'b1); c(CMD_READ, 2'h0, 1'b0); n(3, 1'b1);
    chk(errCnt - e, 2);
  endtask : t_pre
  task automatic t_ap();
    c(CMD_ACT, 2'h0, 1'b0); c(CMD_READ, 2'h0, 1'b1); n(4, 1'b1);
    chk(bankOpen, 4'h1);
    n(1, 1'b1);
    chk({bankOpen, bankPrecharging}, 8'h01);
    n(3, 1'b1);
    @(posedge mclk) #2 continuousPage = 1'b1;
    c(CMD_ACT, 2'h0, 1'b0); c(CMD_READ, 2'h0, 1'b1); n(7, 1'b1);
    chk(bankOpen, 4'h1);
    @(posedge mclk) #2 singleWrite = 1'b1;
    c(CMD_WRITE, 2'h0, 1'b1); n(7, 1'b1);
    chk(bankOpen, 4'h1);
    c(CMD_PRE, 2'h0, 1'b0); n(4, 1'b1);
    @(posedge mclk) #2 continuousPage = 1'b0;
    singleWrite = 1'b0;
  endtask : t_ap
  // first op with auto precharge on bank 0, cut by second op on bank 1
  task automatic t_int(input logic [2:0] a, input logic [2:0] b);
    int w;
    w = wrCnt;
    c(CMD_ACT, 2'h0, 1'b0); c(CMD_ACT, 2'h1, 1'b0); c(a, 2'h0, 1'b1); c(b, 2'h1, 1'b0);
    n(1, 1'b1);
    chk(bankPrecharging[0], 1'b1);
    if (a == CMD_READ) chk(bankOpen, 4'h2);
    else chk(bankOpen, 4'h3);
    // full precharge time before touching bank 0 again
    n(8, 1'b1); c(CMD_PRE, 2'h0, 1'b1); n(4, 1'b1);
    // data on the cutting edge belongs to the new command only
    chk(wrCnt - w, (a == CMD_WRITE) + 4 * (b == CMD_WRITE));
  endtask : t_int
  task automatic t_pd();
    int e;
    e = errCnt;
    n(1, 1'b0); n(1, 1'b1);
    chk({powerDown, activePowerDown}, 2'h2);
    n(1, 1'b1);
    chk(powerDown, 1'b0);
    // overstay kept short of the real limit elsewhere
    n(9, 1'b0);
    chk(powerDownOverstay, 1'b1);
    n(2, 1'b1); c(CMD_ACT, 2'h2, 1'b0); n(2, 1'b0);
    chk(activePowerDown, 1'b1);
    // refresh refused with bank 2 open
    n(2, 1'b1); c(CMD_REF, 2'h0, 1'b0); c(CMD_PRE, 2'h2, 1'b0); n(4, 1'b1);
    chk(errCnt - e, 1);
  endtask : t_pd
  task automatic t_sus();
    c(CMD_ACT, 2'h3, 1'b0); c(CMD_READ, 2'h3, 1'b0); n(1, 1'b0); n(1, 1'b1);
    chk({clockSuspended, readDrive}, 2'h3);
    n(1, 1'b1);
    chk({clockSuspended, readDrive}, 2'h1);
    n(6, 1'b1);
    chk(readDrive, 1'b0);
    c(CMD_PRE, 2'h3, 1'b0); n(4, 1'b1);
  endtask : t_sus
  task automatic t_ref();
    c(CMD_REF, 2'h3, 1'b1); n(1, 1'b1);
    chk({refreshBusy, refreshRow}, 16'h1001);
    // only no-ops through the refresh cycle time
    n(7, 1'b1);
    chk(refreshBusy, 1'b0);
    m.cmd(CMD_REF, 2'h0, 1'b0, 1'b0); n(4, 1'b0);
    chk(selfRefresh, 1'b1);
    // no-ops with clock enable high cover the exit time
    n(4, 1'b1);
    chk(selfRefresh, 1'b0);
    c(CMD_REF, 2'h0, 1'b0); n(1, 1'b1);
    chk(refreshRow, 12'h003);
  endtask : t_ref
  initial begin
    repeat (2) @(posedge mclk);
    #2 reset = 1'b0;
    repeat (4) @(posedge mclk);
    t_pre(); t_ap(); t_pd(); t_sus();
    t_int(CMD_READ, CMD_READ); t_int(CMD_READ, CMD_WRITE);
    t_int(CMD_WRITE, CMD_READ); t_int(CMD_WRITE, CMD_WRITE);
    t_ref();
    test_done();
  end
  initial begin
    #300_000;
    fail_count++;
    test_done();
  end
endmodule : sdp_bank_power_ctrl_tb_top
`default_nettype wire
